// ===== shared/lss_pkg.sv
package lss_pkg;
    localparam int LSS_CHANNELS       = 16;
    localparam int LSS_CLK_MHZ        = 25;
    localparam int LSS_SCK_HALF_NS    = 160;
    localparam int LSS_SCK_HALF_CYC   = (LSS_SCK_HALF_NS * LSS_CLK_MHZ) / 1000;
    localparam int LSS_STROBE_NS      = 320;
    localparam int LSS_STROBE_CYC     = (LSS_STROBE_NS * LSS_CLK_MHZ + 999) / 1000;
    localparam int LSS_LAT_SCK_NS     = 100;
    localparam int LSS_LAT_SCK_CYC    = (LSS_LAT_SCK_NS * LSS_CLK_MHZ + 999) / 1000;
    localparam int LSS_FIFO_DEPTH     = 4;
    localparam logic [15:0] LSS_TEST_SEED = 16'hACE1;
    localparam logic [15:0] LSS_LFSR_TAPS = 16'hB400;
    localparam logic [15:0] LSS_RESET_WORD = 16'h0000;

    typedef enum logic [4:0] {
        LSS_IDLE   = 5'h01,
        LSS_LOW    = 5'h02,
        LSS_HIGH   = 5'h04,
        LSS_STROBE = 5'h08,
        LSS_GAP    = 5'h10
    } lss_state_t;
endpackage

// ===== shared/lss_if.sv
`timescale 1ns/1ns
interface lss_if;
    logic        shift_clk;
    logic        serial_in;
    logic        transfer_strobe;
    logic        blank;
    logic        serial_out;

    modport sink (
        input  shift_clk,
        input  serial_in,
        input  transfer_strobe,
        input  blank,
        output serial_out
    );
    modport ctrl (
        output shift_clk,
        output serial_in,
        output transfer_strobe,
        output blank,
        input  serial_out
    );
endinterface

// ===== hdl/lss_fifo.sv
`timescale 1ns/1ns
module lss_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // System clock
    input  wire logic             reset_n,   // Sync reset
    input  wire logic             clk_en,    // Freeze when low
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Not full
    input  wire logic [WIDTH-1:0] in_data,   // Write word
    output logic                  out_valid, // Not empty
    input  wire logic             out_ready, // Read accept
    output logic      [WIDTH-1:0] out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign out_valid = wr_ff != rd_ff;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ff[AW-1:0]];

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else if (clk_en) begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop)  rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule // lss_fifo

// ===== hdl/lss_sink.sv
`timescale 1ns/1ns
// Contract
// - Serial input enters LSB on shift edge
// - Whole register shifts toward MSB each edge
// - Serial output shows register MSB
// - Register and latch are sixteen bits
// - Strobe rising edge copies register to latch
// - Strobe refills register with test pattern
// - Controller strobes once per loaded word
// - Blank high forces all outputs off
// - Blank low: output follows latch bit
// - Power-up contents are arbitrary
// - Controller loads data before releasing blank
// - Controller holds blank high from power-on
// - Controller zeroes bits of unloaded channels; lss_ctrl shifts wr_data out as given and zeroes nothing
// - All channels switch together
module lss_sink import lss_pkg::*; #(
    parameter int CHANNELS = LSS_CHANNELS
) (
    input  wire logic                clk,            // System clock
    input  wire logic                reset_n,        // Sync reset
    input  wire logic                clk_en,         // Freeze when low
    lss_if.sink                      link,           // Pins from controller
    output logic      [CHANNELS-1:0] sink_channel_n  // Sink on, one per channel
);
    initial begin
        if (CHANNELS != LSS_CHANNELS) $error("CHANNELS must be 16");
    end
    logic [2:0] sck_sync_ff;
    logic [2:0] lat_sync_ff;
    logic [1:0] din_sync_ff;
    logic [1:0] blk_sync_ff;
    logic [CHANNELS-1:0] shift_ff;
    logic [CHANNELS-1:0] latch_ff;
    logic [CHANNELS-1:0] lfsr_ff;
    logic [CHANNELS-1:0] out_ff;
    logic                sck_rise;
    logic                lat_rise;

    // Stage 0 feeds stage 1 only; edges are taken from stages 1 and 2
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_sync_ff <= '0;
            lat_sync_ff <= '0;
            din_sync_ff <= '0;
            blk_sync_ff <= 2'b11;
        end else if (clk_en) begin
            sck_sync_ff <= {sck_sync_ff[1:0], link.shift_clk};
            lat_sync_ff <= {lat_sync_ff[1:0], link.transfer_strobe};
            din_sync_ff <= {din_sync_ff[0], link.serial_in};
            blk_sync_ff <= {blk_sync_ff[0], link.blank};
        end
    end
    assign sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
    assign lat_rise = lat_sync_ff[1] && !lat_sync_ff[2];

    // Free-running pattern stands in for the unfixed test content
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lfsr_ff <= LSS_TEST_SEED;
        end else if (clk_en) begin
            lfsr_ff <= {lfsr_ff[CHANNELS-2:0], ^(lfsr_ff & LSS_LFSR_TAPS)};
        end
    end

    // Reset only for simulation sanity; real part powers up random
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_ff <= LSS_RESET_WORD;
        end else if (clk_en) begin
            if (lat_rise) begin
                shift_ff <= lfsr_ff;
            end else if (sck_rise) begin
                shift_ff <= {shift_ff[CHANNELS-2:0], din_sync_ff[1]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_ff <= LSS_RESET_WORD;
        end else if (clk_en && lat_rise) begin
            latch_ff <= shift_ff;
        end
    end

    // One register stage, so every channel moves on the same edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_ff <= '0;
        end else if (clk_en) begin
            out_ff <= blk_sync_ff[1] ? '0 : latch_ff;
        end
    end

    assign sink_channel_n  = out_ff;
    assign link.serial_out = shift_ff[CHANNELS-1];
endmodule // lss_sink

// ===== hdl/lss_ctrl.sv
`timescale 1ns/1ns
module lss_ctrl import lss_pkg::*; #(
    parameter int CHANNELS = LSS_CHANNELS,
    parameter int DEPTH    = LSS_FIFO_DEPTH
) (
    input  wire logic                clk,       // System clock
    input  wire logic                reset_n,   // Sync reset
    input  wire logic                clk_en,    // Freeze when low
    lss_if.ctrl                      link,      // Pins to sink
    input  wire logic                wr_valid,  // Word offered
    output logic                     wr_ready,  // FIFO has room
    input  wire logic [CHANNELS-1:0] wr_data,   // Bit n = channel n
    input  wire logic                blank_req, // Request outputs off
    output logic                     busy,      // Word in flight
    output logic                     loaded     // A word has been strobed
);
    initial begin
        if (LSS_SCK_HALF_CYC < 1) $error("Shift half period too short");
        if (CHANNELS != LSS_CHANNELS) $error("CHANNELS must be 16");
    end
    localparam int CW = 8;
    lss_state_t          state_ff;
    logic [CW-1:0]       cnt_ff;
    logic [4:0]          bit_ff;
    logic [CHANNELS-1:0] word_ff;
    logic                loaded_ff;
    logic                q_valid;
    logic                q_ready;
    logic [CHANNELS-1:0] q_data;
    logic                cnt_done;

    lss_fifo #(.WIDTH(CHANNELS), .DEPTH(DEPTH)) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .in_valid (wr_valid),
        .in_ready (wr_ready),
        .in_data  (wr_data),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data (q_data)
    );

    assign q_ready  = (state_ff == LSS_IDLE);
    assign cnt_done = (cnt_ff == '0);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= LSS_IDLE;
            cnt_ff   <= '0;
            bit_ff   <= '0;
            word_ff  <= '0;
        end else if (clk_en) begin
            case (state_ff)
                LSS_IDLE: begin
                    if (q_valid) begin
                        word_ff  <= q_data;
                        bit_ff   <= 5'(CHANNELS - 1);
                        cnt_ff   <= CW'(LSS_SCK_HALF_CYC - 1);
                        state_ff <= LSS_LOW;
                    end
                end
                LSS_LOW: begin
                    if (cnt_done) begin
                        cnt_ff   <= CW'(LSS_SCK_HALF_CYC - 1);
                        state_ff <= LSS_HIGH;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                LSS_HIGH: begin
                    if (cnt_done) begin
                        cnt_ff <= CW'(LSS_SCK_HALF_CYC - 1);
                        if (bit_ff == '0) begin
                            cnt_ff   <= CW'(LSS_STROBE_CYC - 1);
                            state_ff <= LSS_STROBE;
                        end else begin
                            bit_ff   <= bit_ff - 1'b1;
                            state_ff <= LSS_LOW;
                        end
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                LSS_STROBE: begin
                    if (cnt_done) begin
                        cnt_ff   <= CW'(LSS_STROBE_CYC + LSS_LAT_SCK_CYC - 1);
                        state_ff <= LSS_GAP;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                LSS_GAP: begin
                    // Keeps next shift edge clear of the strobe edge
                    if (cnt_done) state_ff <= LSS_IDLE;
                    else cnt_ff <= cnt_ff - 1'b1;
                end
                default: state_ff <= LSS_IDLE;
            endcase
        end
    end

    // Exactly one strobe per fully shifted word
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            loaded_ff <= 1'b0;
        end else if (clk_en && state_ff == LSS_STROBE && cnt_done) begin
            loaded_ff <= 1'b1;
        end
    end

    assign link.shift_clk       = (state_ff == LSS_HIGH);
    assign link.serial_in       = (state_ff == LSS_LOW || state_ff == LSS_HIGH)
                                  ? word_ff[bit_ff[3:0]] : 1'b0;
    assign link.transfer_strobe = (state_ff == LSS_STROBE);
    // Blank held from reset until a word is in the latch
    assign link.blank           = !loaded_ff || blank_req;
    assign busy                 = (state_ff != LSS_IDLE);
    assign loaded               = loaded_ff;
endmodule // lss_ctrl

// ===== bench/lss_assertions.sv
`timescale 1ns/1ns
module lss_assertions (
    input wire logic clk,             // System clock
    input wire logic reset_n,         // Sync reset
    input wire logic shift_clk,       // Link clock
    input wire logic serial_in,       // Link data
    input wire logic transfer_strobe, // Latch strobe
    input wire logic blank,           // Outputs off
    input wire logic serial_out       // Chain output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [4:0] sck_age_ff;
    logic [4:0] stb_age_ff;
    logic [4:0] n_shift_ff;
    logic       sck_d_ff;
    logic       stb_d_ff;
    logic       seen_ff;
    always_ff @(posedge clk) begin
        sck_d_ff <= reset_n & shift_clk;
        stb_d_ff <= reset_n & transfer_strobe;
    end
    // Ages saturate so idle periods never wrap back into the window
    always_ff @(posedge clk) begin
        if (!reset_n) sck_age_ff <= 5'h1F;
        else if (shift_clk && !sck_d_ff) sck_age_ff <= 5'h00;
        else if (sck_age_ff != 5'h1F) sck_age_ff <= sck_age_ff + 5'h01;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) stb_age_ff <= 5'h1F;
        else if (transfer_strobe && !stb_d_ff) stb_age_ff <= 5'h00;
        else if (stb_age_ff != 5'h1F) stb_age_ff <= stb_age_ff + 5'h01;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) n_shift_ff <= 5'h00;
        else if (transfer_strobe && !stb_d_ff) n_shift_ff <= 5'h00;
        else if (shift_clk && !sck_d_ff) n_shift_ff <= n_shift_ff + 5'h01;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) seen_ff <= 1'b0;
        else if (transfer_strobe) seen_ff <= 1'b1;
    end
    property p_serial_out; $changed(serial_out) |-> sck_age_ff <= 5'h06 || stb_age_ff <= 5'h06; endproperty
    property p_blank_start; $rose(reset_n) |-> blank; endproperty
    property p_blank_late; $fell(blank) |-> seen_ff; endproperty
    property p_one_strobe; $rose(transfer_strobe) |-> n_shift_ff == 5'h10; endproperty
    property p_stb_width; $rose(transfer_strobe) |-> transfer_strobe[*8] ##1 !transfer_strobe; endproperty
    property p_sck_high; $rose(shift_clk) |-> shift_clk[*4] ##1 !shift_clk; endproperty
    property p_sin_hold; shift_clk |-> $stable(serial_in); endproperty
    property p_sck_quiet; transfer_strobe |-> !shift_clk; endproperty
    a_serial_out: assert property (p_serial_out) else $error("serial_out moved off edge");
    a_blank_start: assert property (p_blank_start) else $error("blank low at start");
    a_blank_late: assert property (p_blank_late) else $error("blank dropped early");
    a_one_strobe: assert property (p_one_strobe) else $error("strobe count wrong");
    a_stb_width: assert property (p_stb_width) else $error("strobe width");
    a_sck_high: assert property (p_sck_high) else $error("shift clock width");
    a_sin_hold: assert property (p_sin_hold) else $error("serial_in moved");
    a_sck_quiet: assert property (p_sck_quiet) else $error("shift during strobe");
    c_strobe: cover property ($rose(transfer_strobe));
    c_unblank: cover property ($fell(blank));
    c_serial_out: cover property ($changed(serial_out));
endmodule // lss_assertions

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wr_valid = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic        blank_req = 1'b0;
    logic        wr_ready;
    logic        busy;
    logic        loaded;
    logic [15:0] sink_channel_n;
    // Last word leaves channels 0 and 15 off, as if unloaded
    logic [15:0] words [5] = '{16'h8001, 16'hFFFF, 16'h0000, 16'hA5C3, 16'h7FFE};
    logic [15:0] cur = 16'h0000;
    logic        stb_d = 1'b0;
    logic        sck_d = 1'b0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_stb = 0;
    int          n_bit = 0;
    int          n_acc = 0;
    always #20 clk = ~clk;
    lss_if lnk ();
    lss_ctrl lss_ctrl_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .blank_req(blank_req), .busy(busy), .loaded(loaded));
    lss_sink lss_sink_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk),
        .sink_channel_n(sink_channel_n));
    lss_assertions lss_assertions_i (.clk(clk), .reset_n(reset_n), .shift_clk(lnk.shift_clk),
        .serial_in(lnk.serial_in), .transfer_strobe(lnk.transfer_strobe),
        .blank(lnk.blank), .serial_out(lnk.serial_out));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Wire monitor: values seen here are those before the edge
    always @(posedge clk) begin
        stb_d <= lnk.transfer_strobe;
        sck_d <= lnk.shift_clk;
        if (lnk.transfer_strobe && !stb_d && n_stb < 5) begin
            cur = words[n_stb];
            check({15'h0000, lnk.serial_out}, {15'h0000, cur[15]});
            check(16'(n_bit), 16'h0010);
            n_bit = 0;
        end
        if (!lnk.transfer_strobe && stb_d) begin
            check(sink_channel_n, (n_stb == 0) ? 16'h0000 : cur);
            n_stb++;
        end
        // Latch keeps the previous word while the next one shifts
        if (lnk.shift_clk && !sck_d) begin
            check(sink_channel_n, (n_stb == 0) ? 16'h0000 : words[n_stb - 1]);
            n_bit++;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #5;
        check(sink_channel_n, 16'h0000);
        check({13'h0000, busy, loaded, lnk.blank}, 16'h0001);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            if (wr_valid && wr_ready) n_acc++;
            wr_valid <= 1'b1;
            wr_data <= words[n_acc % 5];
        end
        @(posedge clk);
        wr_valid <= 1'b0;
        check(16'(n_acc), 16'h0005);
        for (int i = 0; i < 2000 && n_stb < 5; i++) @(posedge clk);
        check(16'(n_stb), 16'h0005);
        repeat (30) @(posedge clk);
        #5;
        check({14'h0000, busy, loaded}, 16'h0001);
        @(posedge clk);
        blank_req <= 1'b1;
        repeat (10) @(posedge clk);
        #5;
        check({15'h0000, lnk.blank}, 16'h0001);
        check(sink_channel_n, 16'h0000);
        @(posedge clk);
        blank_req <= 1'b0;
        repeat (10) @(posedge clk);
        #5;
        check(sink_channel_n, words[4]);
        end_sim();
    end
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule // testbench
